//--- hdl/aaf_pkg.sv
`default_nettype none
package aaf_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_FILT_CFG = 8'h00;
    localparam logic [7:0] ADDR_TUNE_CTL = 8'h04;
    localparam logic [7:0] ADDR_CONV_CFG = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_SAMPLE = 8'h10;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int HPF_LSB = 0;
    localparam int LPF_SCALE_LSB = 4;
    localparam int LPF_BASE_BIT = 8;
    localparam int TWOS_BIT = 0;
    localparam int STAB_EN_BIT = 1;
    localparam logic [2:0] HPF_RST = 3'h0;
    localparam logic [2:0] LPF_SCALE_RST = 3'h3;
    localparam logic [2:0] LPF_SCALE_MAX = 3'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // Timing counts
    // ----------------------------------------
    localparam int TUNE_CYCLES = 512;
    localparam logic [9:0] TUNE_LAST = 10'(TUNE_CYCLES - 1);
    localparam int LOCK_CYCLES = 8;
    localparam logic [3:0] LOCK_LAST = 4'(LOCK_CYCLES - 1);
    localparam int PIPE_STAGES = 4;
    localparam int SAMPLE_W = 12;
    localparam int FRAME_BITS = 12;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        AAF_TUNE_IDLE,
        AAF_TUNE_RUN
    } aaf_tune_state_t;

    typedef struct packed {
        logic [2:0] hpf_ratio;
        logic [2:0] lpf_scale;
        logic lpf_base;
        logic twos_comp;
        logic stab_en;
    } aaf_cfg_t;

    typedef struct packed {
        logic data;
        logic frame_clk;
        logic bit_clk;
    } aaf_serial_t;

endpackage
`default_nettype wire

//--- hdl/aaf_pipe.sv
`timescale 1ns/1ps
`default_nettype none
module aaf_pipe (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [aaf_pkg::PIPE_STAGES*3-1:0] stage_code,
    input wire logic twos_comp,
    output logic [aaf_pkg::SAMPLE_W-1:0] sample,
    output logic sample_vld
);
    import aaf_pkg::*;

    // ----------------------------------------
    // Stage pipeline
    // ----------------------------------------
    logic [PIPE_STAGES*3-1:0] part_r [PIPE_STAGES];
    logic [PIPE_STAGES-1:0] vld_r;

    // Each stage takes a new sample every clock while later stages work on older ones
    genvar g;
    generate
        for (g = 0; g < PIPE_STAGES; g++) begin : g_stage
            if (g == 0) begin : g_first
                always_ff @(posedge aclk) begin
                    if (!aresetn) begin
                        part_r[g] <= '0;
                        vld_r[g] <= 1'b0;
                    end else begin
                        part_r[g] <= stage_code;
                        vld_r[g] <= 1'b1;
                    end
                end
            end else begin : g_next
                always_ff @(posedge aclk) begin
                    if (!aresetn) begin
                        part_r[g] <= '0;
                        vld_r[g] <= 1'b0;
                    end else begin
                        part_r[g] <= part_r[g-1];
                        vld_r[g] <= vld_r[g-1];
                    end
                end
            end
        end
    endgenerate

    // Digital correction: 3-bit stage codes overlap by one bit
    function automatic logic [SAMPLE_W-1:0] correct(input logic [PIPE_STAGES*3-1:0] c);
        logic [SAMPLE_W+1:0] acc;
        acc = '0;
        for (int i = 0; i < PIPE_STAGES; i++) begin
            acc = 14'(acc << 2) + 14'(c[(PIPE_STAGES-1-i)*3 +: 3]);
        end
        return (acc[SAMPLE_W+1:SAMPLE_W] != 2'b00) ? {SAMPLE_W{1'b1}} : acc[SAMPLE_W-1:0];
    endfunction

    // Corrected output word, optional twos-complement format
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample <= '0;
            sample_vld <= 1'b0;
        end else begin
            sample <= correct(part_r[PIPE_STAGES-1]) ^ {twos_comp, 11'h000};
            sample_vld <= vld_r[PIPE_STAGES-1];
        end
    end
endmodule
`default_nettype wire

//--- hdl/aaf_ser.sv
`timescale 1ns/1ps
`default_nettype none
module aaf_ser (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [aaf_pkg::SAMPLE_W-1:0] word,
    input wire logic word_vld,
    output aaf_pkg::aaf_serial_t ser
);
    import aaf_pkg::*;

    logic [SAMPLE_W-1:0] shift_r;
    logic [3:0] bit_r;

    // Load one word per frame and shift it out MSB first, frame marks first half
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_r <= '0;
            bit_r <= 4'h0;
            ser <= '0;
        end else begin
            if (bit_r == 4'(FRAME_BITS) || bit_r == 4'h0 && word_vld) begin
                shift_r <= word;
                bit_r <= word_vld ? 4'h1 : 4'h0;
                ser.data <= word[SAMPLE_W-1];
                ser.frame_clk <= word_vld;
            end else begin
                shift_r <= {shift_r[SAMPLE_W-2:0], 1'b0};
                bit_r <= (bit_r == 4'h0) ? 4'h0 : 4'(bit_r + 4'h1);
                ser.data <= shift_r[SAMPLE_W-2];
                ser.frame_clk <= (bit_r < 4'(FRAME_BITS / 2)) && (bit_r != 4'h0);
            end
            ser.bit_clk <= ~ser.bit_clk;
        end
    end
endmodule
`default_nettype wire

//--- hdl/aaf_top.sv
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module aaf_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [aaf_pkg::PIPE_STAGES*3-1:0] stage_code,
    input wire logic tune_cmp,
    input wire logic rate_change,
    output logic [2:0] hpf_ratio,
    output logic [2:0] lpf_scale,
    output logic lpf_base,
    output logic [5:0] cap_trim,
    output logic tune_active,
    output logic stab_bypass,
    output logic stab_locked,
    output logic clk_int,
    output aaf_pkg::aaf_serial_t ser_out
);
    import aaf_pkg::*;

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    aaf_cfg_t cfg_r;
    aaf_tune_state_t tune_state_r;
    logic [9:0] tune_cnt_r;
    logic [5:0] trim_r;
    logic [3:0] lock_cnt_r;
    logic locked_r;
    logic clk_half_r;
    logic [SAMPLE_W-1:0] sample;
    logic sample_vld;
    logic [SAMPLE_W-1:0] last_sample_r;
    logic tune_start;

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_write;
    logic wr_hit;

    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_hit = (awaddr_r == ADDR_FILT_CFG) || (awaddr_r == ADDR_TUNE_CTL)
        || (awaddr_r == ADDR_CONV_CFG);

    // Address and data captured in either order, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Unmapped addresses are answered with a slave error
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration fields written through byte lane 0 and 1
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r.hpf_ratio <= HPF_RST;
            cfg_r.lpf_scale <= LPF_SCALE_RST;
            cfg_r.lpf_base <= 1'b0;
            cfg_r.twos_comp <= 1'b0;
            cfg_r.stab_en <= 1'b1;
        end else if (do_write && awaddr_r == ADDR_FILT_CFG) begin
            if (wstrb_r[0]) begin
                cfg_r.hpf_ratio <= wdata_r[HPF_LSB +: 3];
                if (wdata_r[LPF_SCALE_LSB +: 3] <= LPF_SCALE_MAX) begin
                    cfg_r.lpf_scale <= wdata_r[LPF_SCALE_LSB +: 3];
                end
            end
            if (wstrb_r[1]) begin
                cfg_r.lpf_base <= wdata_r[LPF_BASE_BIT];
            end
        end else if (do_write && awaddr_r == ADDR_CONV_CFG && wstrb_r[0]) begin
            cfg_r.twos_comp <= wdata_r[TWOS_BIT];
            cfg_r.stab_en <= wdata_r[STAB_EN_BIT];
        end
    end

    assign tune_start = do_write && awaddr_r == ADDR_TUNE_CTL && wstrb_r[0] && wdata_r[0];

    // ----------------------------------------
    // Capacitor tuning sequence
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tune_state_r <= AAF_TUNE_IDLE;
            tune_cnt_r <= 10'h000;
        end else begin
            unique case (tune_state_r)
                AAF_TUNE_IDLE: begin
                    tune_cnt_r <= 10'h000;
                    if (tune_start) begin
                        tune_state_r <= AAF_TUNE_RUN;
                    end
                end
                AAF_TUNE_RUN: begin
                    tune_cnt_r <= 10'(tune_cnt_r + 10'h001);
                    if (tune_cnt_r == TUNE_LAST) begin
                        tune_state_r <= AAF_TUNE_IDLE;
                    end
                end
                default: begin
                    tune_state_r <= AAF_TUNE_IDLE;
                end
            endcase
        end
    end

    // Trim code steps only while tuning; held otherwise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_r <= 6'h20;
        end else if (tune_state_r == AAF_TUNE_RUN) begin
            if (tune_cmp && trim_r != 6'h3F) begin
                trim_r <= 6'(trim_r + 6'h01);
            end else if (!tune_cmp && trim_r != 6'h00) begin
                trim_r <= 6'(trim_r - 6'h01);
            end
        end
    end

    // ----------------------------------------
    // Duty cycle stabilizer model
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_cnt_r <= 4'h0;
            locked_r <= 1'b0;
        end else if (rate_change || !cfg_r.stab_en) begin
            lock_cnt_r <= 4'h0;
            locked_r <= 1'b0;
        end else if (!locked_r) begin
            lock_cnt_r <= 4'(lock_cnt_r + 4'h1);
            locked_r <= (lock_cnt_r == LOCK_LAST);
        end
    end

    // Regenerated internal clock toggles each edge, even duty when locked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_half_r <= 1'b0;
        end else begin
            clk_half_r <= ~clk_half_r;
        end
    end

    // ----------------------------------------
    // Converter and serializer
    // ----------------------------------------
    aaf_pipe u_pipe (
        .aclk(aclk),
        .aresetn(aresetn),
        .stage_code(stage_code),
        .twos_comp(cfg_r.twos_comp),
        .sample(sample),
        .sample_vld(sample_vld)
    );

    aaf_ser u_ser (
        .aclk(aclk),
        .aresetn(aresetn),
        .word(sample),
        .word_vld(sample_vld),
        .ser(ser_out)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_sample_r <= '0;
        end else if (sample_vld) begin
            last_sample_r <= sample;
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                unique case (s_axi_araddr[7:0])
                    ADDR_FILT_CFG: s_axi_rdata <= {23'h0, cfg_r.lpf_base, 1'b0,
                        cfg_r.lpf_scale, 1'b0, cfg_r.hpf_ratio};
                    ADDR_TUNE_CTL: s_axi_rdata <= {31'h0, tune_state_r == AAF_TUNE_RUN};
                    ADDR_CONV_CFG: s_axi_rdata <= {30'h0, cfg_r.stab_en, cfg_r.twos_comp};
                    ADDR_STATUS: s_axi_rdata <= {16'h0, 2'h0, trim_r, 6'h0, locked_r,
                        tune_state_r == AAF_TUNE_RUN};
                    ADDR_SAMPLE: s_axi_rdata <= {20'h0, last_sample_r};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Registered control outputs
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hpf_ratio <= HPF_RST;
            lpf_scale <= LPF_SCALE_RST;
            lpf_base <= 1'b0;
            cap_trim <= 6'h20;
            tune_active <= 1'b0;
            stab_bypass <= 1'b0;
            stab_locked <= 1'b0;
            clk_int <= 1'b0;
        end else begin
            hpf_ratio <= cfg_r.hpf_ratio;
            lpf_scale <= cfg_r.lpf_scale;
            lpf_base <= cfg_r.lpf_base;
            cap_trim <= trim_r;
            tune_active <= tune_state_r == AAF_TUNE_RUN;
            stab_bypass <= !cfg_r.stab_en;
            stab_locked <= locked_r;
            clk_int <= (cfg_r.stab_en && locked_r) ? ~clk_half_r : ~clk_int;
        end
    end
endmodule
`default_nettype wire

//--- testbench/aaf_chk.sv
`timescale 1ns/1ps
`default_nettype none
module aaf_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rate_change,
    input wire logic [2:0] lpf_scale,
    input wire logic [5:0] cap_trim,
    input wire logic tune_active,
    input wire logic stab_bypass,
    input wire logic stab_locked,
    input wire logic clk_int
);
    logic [9:0] run_cnt_r;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Cycles already spent in the current tuning run
    always_ff @(posedge aclk) begin
        if (!aresetn || !tune_active) begin
            run_cnt_r <= 10'h000;
        end else begin
            run_cnt_r <= run_cnt_r + 10'h001;
        end
    end
    // -----------------------------
    // Properties
    // -----------------------------
    sequence s_settle;
        (!rate_change && !stab_bypass) [*8] ##1 (!rate_change && !stab_bypass) [*3];
    endsequence
    property p_run_max;
        tune_active |-> run_cnt_r <= 10'h1FF;
    endproperty
    property p_run_end;
        $fell(tune_active) |-> $past(run_cnt_r) == 10'h1FF;
    endproperty
    property p_trim_hold;
        !tune_active && !$past(tune_active) |-> $stable(cap_trim);
    endproperty
    property p_scale_ok;
        lpf_scale != 3'h7;
    endproperty
    property p_lock_wait;
        rate_change |-> ##2 !stab_locked [*8];
    endproperty
    property p_lock_gain;
        rate_change ##1 s_settle |-> stab_locked;
    endproperty
    property p_clk_half;
        !stab_bypass && $past(aresetn) |-> clk_int != $past(clk_int);
    endproperty
    property p_bdone;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    property p_rdone;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_run_max: assert property (p_run_max) else $error("tuning run too long");
    a_run_end: assert property (p_run_end) else $error("tuning run length wrong");
    a_trim_hold: assert property (p_trim_hold) else $error("trim moved while idle");
    a_scale_ok: assert property (p_scale_ok) else $error("scale code out of range");
    a_lock_wait: assert property (p_lock_wait) else $error("lock came too early");
    a_lock_gain: assert property (p_lock_gain) else $error("lock never came");
    a_clk_half: assert property (p_clk_half) else $error("internal clock stuck");
    a_bdone: assert property (p_bdone) else $error("write response held");
    a_rdone: assert property (p_rdone) else $error("read response held");
endmodule
bind aaf_top aaf_chk u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
    .s_axi_rready, .rate_change, .lpf_scale, .cap_trim, .tune_active, .stab_bypass,
    .stab_locked, .clk_int);
`default_nettype wire

//--- testbench/aaf_host.sv
`timescale 1ns/1ps
`default_nettype none
module aaf_host (
    input wire logic aclk,
    output logic [31:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [31:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // Idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    // Write cycle; released payload is scrambled so stale values never match
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= {24'h000000, a};
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1 && s_axi_awvalid === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~s_axi_awaddr;
            end
            if (s_axi_wready === 1'b1 && s_axi_wvalid === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~s_axi_wdata;
            end
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // Read cycle
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= {24'h000000, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1 && s_axi_arvalid === 1'b1) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~s_axi_araddr;
            end
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- testbench/aaf_tuning_and_adc_sampling_tb.sv
`timescale 1ns/1ps
`default_nettype none
module aaf_tuning_and_adc_sampling_tb;
    import aaf_pkg::*;
    logic aclk, aresetn, tune_cmp, rate_change, lpf_base, tune_active, stab_bypass;
    logic stab_locked, clk_int, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd, s0;
    logic [11:0] stage_code;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [2:0] hpf_ratio, lpf_scale;
    logic [5:0] cap_trim;
    aaf_serial_t ser_out;
    int errors, n_tests;
    aaf_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stage_code, .tune_cmp, .rate_change,
        .hpf_ratio, .lpf_scale, .lpf_base, .cap_trim, .tune_active, .stab_bypass,
        .stab_locked, .clk_int, .ser_out);
    aaf_host u_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // Clock and a comparator that flips every cycle
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) tune_cmp <= (tune_cmp !== 1'b1);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        u_host.axi_read(a, rd, rsp);
        chk(rd & m, e);
    endtask
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Reset values, idle tuner, unmapped places
    task automatic t_reset();
        @(negedge aclk);
        chk(32'(lpf_scale), 32'(LPF_SCALE_RST));
        chk(32'(hpf_ratio), 32'(HPF_RST));
        chk(32'(tune_active), 32'h0);
        chk(32'(cap_trim), 32'h20);
        rd_chk(ADDR_FILT_CFG, 32'h1FF, 32'h30);
        rd_chk(ADDR_CONV_CFG, 32'h3, 32'h2);
        rd_chk(ADDR_STATUS, 32'h3F01, 32'h2000);
        u_host.axi_read(8'h20, rd, rsp);
        chk(32'(rsp), 32'(RESP_SLVERR));
        chk(rd, 32'h0);
        u_host.axi_write(8'h24, 32'h1, rsp);
        chk(32'(rsp), 32'(RESP_SLVERR));
        $display("t_reset done");
    endtask
    // Every high-pass code, every scale, both base divisors, refused scale 7
    task automatic t_filt();
        logic [31:0] v;
        for (int k = 0; k < 8; k++) begin
            v = 32'(k) | (32'(k % 7) << 4) | (32'(k & 1) << 8);
            u_host.axi_write(ADDR_FILT_CFG, v, rsp);
            rd_chk(ADDR_FILT_CFG, 32'h1FF, v);
            chk(32'({lpf_base, 1'b0, lpf_scale, 1'b0, hpf_ratio}), v);
        end
        u_host.axi_write(ADDR_FILT_CFG, 32'h72, rsp);
        @(negedge aclk);
        chk(32'(lpf_scale), 32'h0);
        $display("t_filt done");
    endtask
    // One tuning run after a scale setting; length, readback, trim hold
    task automatic t_tune(input int sc);
        int n;
        logic [5:0] trim;
        n = 0;
        fork
            repeat (700) begin
                @(negedge aclk);
                if (tune_active === 1'b1) n++;
            end
            begin
                u_host.axi_write(ADDR_FILT_CFG, 32'(sc) << 4, rsp);
                u_host.axi_write(ADDR_TUNE_CTL, 32'h1, rsp);
                rd_chk(ADDR_TUNE_CTL, 32'h1, 32'h1);
                rd_chk(ADDR_STATUS, 32'h1, 32'h1);
            end
        join
        chk(32'(n), 32'(TUNE_CYCLES));
        rd_chk(ADDR_TUNE_CTL, 32'h1, 32'h0);
        trim = cap_trim;
        repeat (40) @(negedge aclk);
        chk(32'(cap_trim), 32'(trim));
        $display("t_tune done");
    endtask
    // Stabilizer bypass and relock, internal clock, sample format, framing
    task automatic t_conv();
        int f;
        u_host.axi_write(ADDR_CONV_CFG, 32'h0, rsp);
        @(negedge aclk);
        chk(32'(stab_bypass), 32'h1);
        u_host.axi_write(ADDR_CONV_CFG, 32'h2, rsp);
        @(negedge aclk);
        chk(32'(stab_bypass), 32'h0);
        @(posedge aclk) rate_change <= 1'b1;
        @(posedge aclk) rate_change <= 1'b0;
        @(negedge aclk);
        chk(32'(stab_locked), 32'h0);
        repeat (12) @(negedge aclk);
        chk(32'(stab_locked), 32'h1);
        f = int'(clk_int);
        @(negedge aclk);
        chk(32'(clk_int), 32'(f == 0));
        @(posedge aclk) stage_code <= 12'h5A3;
        repeat (10) @(posedge aclk);
        u_host.axi_read(ADDR_SAMPLE, s0, rsp);
        for (int k = 1; k < 9; k++) begin
            @(posedge aclk) stage_code <= 12'(k * 12'h1C7);
        end
        @(posedge aclk) stage_code <= 12'h5A3;
        u_host.axi_write(ADDR_CONV_CFG, 32'h3, rsp);
        repeat (10) @(posedge aclk);
        rd_chk(ADDR_SAMPLE, 32'hFFF, s0 ^ 32'h800);
        f = 0;
        repeat (48) begin
            @(negedge aclk);
            if (ser_out.frame_clk === 1'b1 && ser_out.bit_clk !== 1'bx) f++;
        end
        chk(32'(f), 32'd24);
        // One whole frame, MSB first, from the rising frame edge
        while (ser_out.frame_clk !== 1'b0) @(negedge aclk);
        while (ser_out.frame_clk !== 1'b1) @(negedge aclk);
        s0 = 32'h0;
        repeat (12) begin
            s0 = {s0[30:0], ser_out.data};
            @(negedge aclk);
        end
        chk(s0, rd & 32'hFFF);
        $display("t_conv done");
    endtask
    // Watchdog
    initial begin
        repeat (6000) @(posedge aclk);
        errors++;
        print_verdict();
    end
    // Main sequence
    initial begin
        {aresetn, rate_change, stage_code, errors, n_tests} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_filt();
        t_tune(3);
        t_tune(6);
        t_conv();
        print_verdict();
    end
endmodule
`default_nettype wire
